/* File: core/bfs_pkg.sv */
// Shared constants of the buck fault sequencer
package bfs_pkg;
   // Core clock and internal time base
   localparam int CLK_MHZ     = 200;
   localparam int TICK_US     = 1;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
   localparam int DIV_W       = 8;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

   // Times in microseconds, as specified
   localparam int PG_DEGLITCH_US = 200;
   localparam int UV_WAIT_US     = 1000;
   localparam int HICCUP_US      = 7000;
   localparam int CFG_DELAY_US   = 100;
   localparam int CFG_SAMPLE_US  = 100;

   // Same times as counts of time-base ticks
   localparam int PG_DEGLITCH_TICKS = PG_DEGLITCH_US / TICK_US;
   localparam int UV_WAIT_TICKS     = UV_WAIT_US / TICK_US;
   localparam int HICCUP_TICKS      = HICCUP_US / TICK_US;
   localparam int CFG_DELAY_TICKS   = CFG_DELAY_US / TICK_US;
   localparam int CFG_SAMPLE_TICKS  = CFG_SAMPLE_US / TICK_US;

   // Timer counter width, enough for the hiccup interval
   localparam int TMR_W = 13;

   // Mode configuration fields
   localparam int LIM_W  = 2;
   localparam int FREQ_W = 2;
   localparam logic [LIM_W-1:0]  LIM_HIGHEST  = 2'h2;
   localparam logic [LIM_W-1:0]  LIM_FALLBACK = 2'h1;
   localparam logic [FREQ_W-1:0] FREQ_HIGHEST = 2'h2;
   localparam logic [LIM_W-1:0]  LIM_RESET    = 2'h0;
   localparam logic [FREQ_W-1:0] FREQ_RESET   = 2'h0;

   // Sequencer states
   typedef enum logic [3:0] {
      ST_STANDBY,
      ST_LOCKOUT,
      ST_THERMAL,
      ST_CFG_DELAY,
      ST_CFG_SAMPLE,
      ST_PREBIAS,
      ST_SOFTSTART,
      ST_RUN,
      ST_UV_WAIT,
      ST_HICCUP
   } bfs_state_e;
endpackage

/* File: core/bfs_timer.sv */
// Restartable tick counter for deglitch, wait and hiccup intervals
`timescale 1ns/10ps
module bfs_timer (
   input  wire logic                    clk_i,
   input  wire logic                    reset_i,
   input  wire logic                    tick_i,
   input  wire logic                    run_i,
   input  wire logic [bfs_pkg::TMR_W-1:0] limit_i,
   output logic                         done_o
);
   import bfs_pkg::*;

   logic [TMR_W-1:0] count_reg;

   // Count ticks while qualified; drop back to zero the moment it clears
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_reg <= '0;
      end else if (!run_i) begin
         count_reg <= '0;
      end else if (tick_i && (count_reg != limit_i)) begin
         count_reg <= count_reg + TMR_W'(1);
      end
   end

   // Saturates at the limit, so done stays up while still qualified
   assign done_o = run_i && (count_reg == limit_i);
endmodule

/* File: core/bfs_config.sv */
// Mode configuration holder, loaded once per supply cycle
`timescale 1ns/10ps
module bfs_config (
   input  wire logic                     clk_i,
   input  wire logic                     reset_i,
   input  wire logic                     capture_i,
   input  wire logic                     skip_i,
   input  wire logic [bfs_pkg::LIM_W-1:0]  limit_i,
   input  wire logic [bfs_pkg::FREQ_W-1:0] freq_i,
   output logic                          valid_o,
   output logic                          skip_o,
   output logic [bfs_pkg::LIM_W-1:0]       limit_o,
   output logic [bfs_pkg::FREQ_W-1:0]      freq_o
);
   import bfs_pkg::*;

   logic              load;
   logic              clamp;
   logic [LIM_W-1:0]  limit_next;

   // Top current limit is never offered at the top frequency
   assign clamp      = (freq_i == FREQ_HIGHEST) && (limit_i == LIM_HIGHEST);
   assign limit_next = clamp ? LIM_FALLBACK : limit_i;
   assign load       = capture_i && !valid_o;

   // Only the supply reset clears these; nothing else reloads them
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         valid_o <= 1'b0;
         skip_o  <= 1'b0;
         limit_o <= LIM_RESET;
         freq_o  <= FREQ_RESET;
      end else if (load) begin
         valid_o <= 1'b1;
         skip_o  <= skip_i;
         limit_o <= limit_next;
         freq_o  <= freq_i;
      end
   end
endmodule

/* File: core/bfs_sequencer.sv */
// Start-up, protection and power-good sequencer of the step-down converter
`timescale 1ns/10ps
module bfs_sequencer #(
   parameter int PG_DEGLITCH_TICKS = bfs_pkg::PG_DEGLITCH_TICKS,
   parameter int UV_WAIT_TICKS     = bfs_pkg::UV_WAIT_TICKS,
   parameter int HICCUP_TICKS      = bfs_pkg::HICCUP_TICKS,
   parameter int CFG_DELAY_TICKS   = bfs_pkg::CFG_DELAY_TICKS,
   parameter int CFG_SAMPLE_TICKS  = bfs_pkg::CFG_SAMPLE_TICKS
) (
   input  wire logic                       clk_i,
   input  wire logic                       reset_i,
   input  wire logic                       enable_above_on_i,
   input  wire logic                       enable_below_off_i,
   input  wire logic                       supply_lockout_i,
   input  wire logic                       first_thermal_threshold_i,
   input  wire logic                       second_thermal_threshold_i,
   input  wire logic                       feedback_in_window_i,
   input  wire logic                       output_undervoltage_fault_i,
   input  wire logic                       output_overvoltage_fault_i,
   input  wire logic                       near_overvoltage_clamp_i,
   input  wire logic                       valley_overcurrent_limit_i,
   input  wire logic                       reference_above_feedback_i,
   input  wire logic                       external_ramp_lower_i,
   input  wire logic                       softstart_done_i,
   input  wire logic                       zero_current_i,
   input  wire logic                       mode_skip_i,
   input  wire logic [bfs_pkg::LIM_W-1:0]    mode_limit_i,
   input  wire logic [bfs_pkg::FREQ_W-1:0]   mode_freq_i,
   output logic                            raised_pullup_current_o,
   output logic                            softstart_release_o,
   output logic                            softstart_ground_o,
   output logic                            reference_external_o,
   output logic                            switching_enable_o,
   output logic                            low_side_hold_o,
   output logic                            low_side_force_on_o,
   output logic                            low_side_zero_off_o,
   output logic                            negative_limit_enable_o,
   output logic                            pulse_skip_operation_o,
   output logic                            output_in_window_flag_o,
   output logic                            output_in_window_flag_oe_o,
   output logic                            discharge_on_o,
   output logic                            internal_bias_rail_off_o,
   output logic                            hiccup_active_o,
   output logic                            standby_o,
   output logic                            cfg_sampling_o,
   output logic                            cfg_valid_o,
   output logic [bfs_pkg::LIM_W-1:0]         cfg_limit_o,
   output logic [bfs_pkg::FREQ_W-1:0]        cfg_freq_o
);
   import bfs_pkg::*;

   // Registered comparator flags
   logic en_on_reg;
   logic en_off_reg;
   logic lockout_reg;
   logic temp1_reg;
   logic temp2_reg;
   logic window_reg;
   logic uv_reg;
   logic ov_reg;
   logic near_ov_reg;
   logic valley_oc_reg;
   logic ref_gt_fb_reg;
   logic ext_low_reg;
   logic ss_done_reg;
   logic zero_reg;

   // Control state
   bfs_state_e       state_reg;
   bfs_state_e       state_next;
   logic             enable_reg;
   logic             enable_next;
   logic [DIV_W-1:0] div_reg;
   logic             tick;
   logic             bias_off_reg;
   logic             bias_off_next;
   logic             pg_release_reg;
   logic             pg_release_next;
   logic             discharge_reg;
   logic             discharge_next;

   // Timer handshakes
   logic pg_run;
   logic pg_done;
   logic uv_done;
   logic hic_done;
   logic dly_done;
   logic smp_done;
   logic cfg_skip;

   // Decoded state groups
   logic st_ramp;
   logic st_switch;
   logic st_startup;
   logic fault_pg_low;
   logic resume_ok;

   // Every analog flag passes through one flop before the sequencer looks at it
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         en_on_reg     <= 1'b0;
         en_off_reg    <= 1'b1;
         lockout_reg   <= 1'b1;
         temp1_reg     <= 1'b0;
         temp2_reg     <= 1'b0;
         window_reg    <= 1'b0;
         uv_reg        <= 1'b0;
         ov_reg        <= 1'b0;
         near_ov_reg   <= 1'b0;
         valley_oc_reg <= 1'b0;
         ref_gt_fb_reg <= 1'b0;
         ext_low_reg   <= 1'b0;
         ss_done_reg   <= 1'b0;
         zero_reg      <= 1'b0;
      end else begin
         en_on_reg     <= enable_above_on_i;
         en_off_reg    <= enable_below_off_i;
         lockout_reg   <= supply_lockout_i;
         temp1_reg     <= first_thermal_threshold_i;
         temp2_reg     <= second_thermal_threshold_i;
         window_reg    <= feedback_in_window_i;
         uv_reg        <= output_undervoltage_fault_i;
         ov_reg        <= output_overvoltage_fault_i;
         near_ov_reg   <= near_overvoltage_clamp_i;
         valley_oc_reg <= valley_overcurrent_limit_i;
         ref_gt_fb_reg <= reference_above_feedback_i;
         ext_low_reg   <= external_ramp_lower_i;
         ss_done_reg   <= softstart_done_i;
         zero_reg      <= zero_current_i;
      end
   end

   // One microsecond time base; all intervals count these ticks
   assign tick = (div_reg == DIV_LAST);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         div_reg <= '0;
      end else begin
         div_reg <= tick ? '0 : div_reg + DIV_W'(1);
      end
   end

   // Enable hysteresis: on above the turn-on level, off only below turn-off
   assign enable_next = en_on_reg ? 1'b1 :
                        en_off_reg ? 1'b0 : enable_reg;

   // State groups used by the outputs
   assign st_ramp    = (state_reg == ST_PREBIAS) || (state_reg == ST_SOFTSTART) ||
                       (state_reg == ST_RUN) || (state_reg == ST_UV_WAIT);
   assign st_switch  = (state_reg == ST_SOFTSTART) || (state_reg == ST_RUN) ||
                       (state_reg == ST_UV_WAIT);
   assign st_startup = (state_reg == ST_PREBIAS) || (state_reg == ST_SOFTSTART);
   assign resume_ok  = enable_reg && !lockout_reg && !temp1_reg;

   // Timer qualifiers; each restarts when its condition drops
   assign pg_run = (state_reg == ST_RUN) && window_reg && !ov_reg && !uv_reg;

   bfs_timer u_pg_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_i  (tick),
      .run_i   (pg_run),
      .limit_i (TMR_W'(PG_DEGLITCH_TICKS)),
      .done_o  (pg_done)
   );

   bfs_timer u_uv_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_i  (tick),
      .run_i   ((state_reg == ST_UV_WAIT) && uv_reg),
      .limit_i (TMR_W'(UV_WAIT_TICKS)),
      .done_o  (uv_done)
   );

   bfs_timer u_hiccup_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_i  (tick),
      .run_i   (state_reg == ST_HICCUP),
      .limit_i (TMR_W'(HICCUP_TICKS)),
      .done_o  (hic_done)
   );

   bfs_timer u_cfg_delay_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_i  (tick),
      .run_i   (state_reg == ST_CFG_DELAY),
      .limit_i (TMR_W'(CFG_DELAY_TICKS)),
      .done_o  (dly_done)
   );

   bfs_timer u_cfg_sample_timer (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .tick_i  (tick),
      .run_i   (state_reg == ST_CFG_SAMPLE),
      .limit_i (TMR_W'(CFG_SAMPLE_TICKS)),
      .done_o  (smp_done)
   );

   // Mode settings are loaded at the end of the sampling window only
   bfs_config u_config (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .capture_i (smp_done),
      .skip_i    (mode_skip_i),
      .limit_i   (mode_limit_i),
      .freq_i    (mode_freq_i),
      .valid_o   (cfg_valid_o),
      .skip_o    (cfg_skip),
      .limit_o   (cfg_limit_o),
      .freq_o    (cfg_freq_o)
   );

   // Sequencer; lockout and heat checked before anything else
   always_comb begin
      state_next = state_reg;
      if (lockout_reg) begin
         state_next = ST_LOCKOUT;
      end else if (temp1_reg) begin
         state_next = ST_THERMAL;
      end else if (!enable_reg) begin
         state_next = ST_STANDBY;
      end else begin
         case (state_reg)
            ST_STANDBY, ST_LOCKOUT, ST_THERMAL: begin
               // Resume reuses a held configuration, never resamples it
               state_next = cfg_valid_o ? ST_PREBIAS : ST_CFG_DELAY;
            end
            ST_CFG_DELAY: begin
               if (dly_done) begin
                  state_next = ST_CFG_SAMPLE;
               end
            end
            ST_CFG_SAMPLE: begin
               if (smp_done) begin
                  state_next = ST_PREBIAS;
               end
            end
            ST_PREBIAS: begin
               if (valley_oc_reg) begin
                  state_next = ST_HICCUP;
               end else if (ref_gt_fb_reg) begin
                  state_next = ST_SOFTSTART;
               end
            end
            ST_SOFTSTART: begin
               if (valley_oc_reg) begin
                  state_next = ST_HICCUP;
               end else if (ss_done_reg) begin
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               if (uv_reg) begin
                  state_next = ST_UV_WAIT;
               end
            end
            ST_UV_WAIT: begin
               if (!uv_reg) begin
                  state_next = ST_RUN;
               end else if (uv_done) begin
                  state_next = ST_HICCUP;
               end
            end
            ST_HICCUP: begin
               if (hic_done) begin
                  state_next = ST_PREBIAS;
               end
            end
            default: begin
               state_next = ST_STANDBY;
            end
         endcase
      end
   end

   // Bias rail cut once the second threshold is passed during shutdown, kept off until the first threshold clears
   assign bias_off_next = (state_reg == ST_THERMAL) && temp2_reg ? 1'b1 :
                          !temp1_reg ? 1'b0 : bias_off_reg;

   // Power-good is held low by any fault or during the ramp
   assign fault_pg_low    = uv_reg || ov_reg || temp1_reg || st_startup;
   assign pg_release_next = pg_done && !fault_pg_low;

   // Discharge covers overvoltage, hiccup, lockout, heat, standby and enable off
   assign discharge_next = !enable_reg || lockout_reg || temp1_reg ||
                           ov_reg || (state_reg == ST_HICCUP) ||
                           (state_reg == ST_STANDBY);

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg      <= ST_STANDBY;
         enable_reg     <= 1'b0;
         bias_off_reg   <= 1'b0;
         pg_release_reg <= 1'b0;
         discharge_reg  <= 1'b1;
      end else begin
         state_reg      <= state_next;
         enable_reg     <= enable_next;
         bias_off_reg   <= bias_off_next;
         pg_release_reg <= pg_release_next;
         discharge_reg  <= discharge_next;
      end
   end

   // Pull-up strength follows the hysteresis state
   assign raised_pullup_current_o = enable_reg;

   // Ramp runs from pre-bias on; grounded whenever not running
   assign softstart_release_o  = st_ramp;
   assign softstart_ground_o   = !st_ramp;
   assign reference_external_o = st_ramp && ext_low_reg;

   // Gate drive requests exist only while switching
   assign switching_enable_o      = st_switch;
   assign low_side_hold_o         = st_switch && valley_oc_reg;
   assign low_side_force_on_o     = st_switch && near_ov_reg;
   assign negative_limit_enable_o = st_switch && near_ov_reg;
   assign pulse_skip_operation_o  = st_switch && cfg_skip;
   // The clamp forces pulse-width operation, so zero-current cut-off yields to it
   assign low_side_zero_off_o = pulse_skip_operation_o && zero_reg &&
                                !near_ov_reg && !valley_oc_reg;

   // Open-drain pin: only ever drives low, enable high while pulling down
   assign output_in_window_flag_o    = 1'b0;
   assign output_in_window_flag_oe_o = !pg_release_reg;

   assign discharge_on_o           = discharge_reg;
   assign internal_bias_rail_off_o = bias_off_reg;
   assign hiccup_active_o          = (state_reg == ST_HICCUP);
   assign standby_o                = (state_reg == ST_STANDBY) && !resume_ok;
   assign cfg_sampling_o           = (state_reg == ST_CFG_SAMPLE);
endmodule

/* File: testbench/bfs_sequencer_assertions.sv */
// Port-level checks of the buck fault sequencer
`timescale 1ns/10ps
module bfs_sequencer_assertions (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic supply_lockout_i,
   input wire logic first_thermal_threshold_i,
   input wire logic near_overvoltage_clamp_i,
   input wire logic valley_overcurrent_limit_i,
   input wire logic softstart_release_o,
   input wire logic softstart_ground_o,
   input wire logic switching_enable_o,
   input wire logic low_side_hold_o,
   input wire logic low_side_force_on_o,
   input wire logic low_side_zero_off_o,
   input wire logic negative_limit_enable_o,
   input wire logic pulse_skip_operation_o,
   input wire logic output_in_window_flag_oe_o,
   input wire logic discharge_on_o,
   input wire logic hiccup_active_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Flags take one edge to register and the state one more
   a_release_before_sw: assert property (switching_enable_o |-> softstart_release_o)
      else $error("switching without ramp release");
   a_lockout_stops: assert property (supply_lockout_i |-> ##2
      !switching_enable_o && !low_side_force_on_o) else $error("lockout left switching on");
   a_thermal_stops: assert property (first_thermal_threshold_i |-> ##2
      !switching_enable_o && softstart_ground_o) else $error("hot die left switching on");
   a_pg_low_ramp: assert property ($rose(switching_enable_o) |-> output_in_window_flag_oe_o)
      else $error("power-good free at ramp start");
   a_valley_hold: assert property (low_side_hold_o |->
      switching_enable_o && $past(valley_overcurrent_limit_i)) else $error("bad valley hold");
   a_clamp_force: assert property ($past(near_overvoltage_clamp_i) && switching_enable_o
      |-> low_side_force_on_o && negative_limit_enable_o) else $error("clamp not applied");
   a_zero_off_skip: assert property (low_side_zero_off_o |-> pulse_skip_operation_o
      && !low_side_force_on_o && !low_side_hold_o) else $error("bad zero-current turn-off");
   a_hiccup_discharge: assert property ($rose(hiccup_active_o) |-> ##1 discharge_on_o [*3])
      else $error("no discharge in hiccup");
endmodule

/* File: testbench/bfs_host_model.sv */
// Host board model: enable pin driver and power-good pull-up
`timescale 1ns/10ps
module bfs_host_model #(
   parameter int MID_CYCLES = 4
) (
   input  wire logic clk_i,
   input  wire logic en_req_i,
   input  wire logic pg_oe_i,
   input  wire logic pg_dat_i,
   output logic      en_on_o,
   output logic      en_off_o,
   output logic      pg_wire_o
);
   int   mid_cnt = 0;
   logic en_lvl  = 1'b0;
   // A slow pin edge sits between the two comparators for a while
   always @(posedge clk_i) begin
      if (en_req_i == en_lvl) mid_cnt <= 0;
      else if (mid_cnt < MID_CYCLES) mid_cnt <= mid_cnt + 1;
      else en_lvl <= en_req_i;
   end
   assign en_on_o   = (mid_cnt == 0) && en_lvl;
   assign en_off_o  = (mid_cnt == 0) && !en_lvl;
   // Pull-up wins whenever the device lets go of power-good
   assign pg_wire_o = pg_oe_i ? pg_dat_i : 1'b1;
endmodule

/* File: testbench/bfs_sequencer_bench.sv */
// Self-checking bench of the buck fault sequencer with its host board
`timescale 1ns/10ps
module bfs_sequencer_bench;
   import bfs_pkg::*;
   localparam int T = TICK_CYCLES;
   logic clk_i = 1'b0, reset_i = 1'b1, en_req = 1'b0, pg_wire, en_on, en_off;
   logic lk = 1'b0, t1 = 1'b0, t2 = 1'b0, win = 1'b0, uv = 1'b0, ov = 1'b0, cl = 1'b0;
   logic oc = 1'b0, rf = 1'b0, ex = 1'b0, ssd = 1'b0, zc = 1'b0, sk = 1'b1;
   logic [LIM_W-1:0] lim = LIM_HIGHEST, clim;
   logic [FREQ_W-1:0] frq = FREQ_HIGHEST, cfrq;
   logic pu, rel, gnd, rext, sw, hold, frc, zoff, neg, psk, oe, dis, boff, hic, stb, smp, cv, pgd;
   int bad_count = 0;
   int n_compared = 0;
   // Short counts keep the run brief; expectations use the same figures
   bfs_sequencer #(.PG_DEGLITCH_TICKS(3), .UV_WAIT_TICKS(4), .HICCUP_TICKS(5),
      .CFG_DELAY_TICKS(3), .CFG_SAMPLE_TICKS(3)) u_bfs_sequencer (.clk_i(clk_i),
      .reset_i(reset_i), .enable_above_on_i(en_on), .enable_below_off_i(en_off),
      .supply_lockout_i(lk), .first_thermal_threshold_i(t1), .second_thermal_threshold_i(t2),
      .feedback_in_window_i(win), .output_undervoltage_fault_i(uv),
      .output_overvoltage_fault_i(ov), .near_overvoltage_clamp_i(cl),
      .valley_overcurrent_limit_i(oc), .reference_above_feedback_i(rf),
      .external_ramp_lower_i(ex), .softstart_done_i(ssd), .zero_current_i(zc),
      .mode_skip_i(sk), .mode_limit_i(lim), .mode_freq_i(frq), .raised_pullup_current_o(pu),
      .softstart_release_o(rel), .softstart_ground_o(gnd), .reference_external_o(rext),
      .switching_enable_o(sw), .low_side_hold_o(hold), .low_side_force_on_o(frc),
      .low_side_zero_off_o(zoff), .negative_limit_enable_o(neg), .pulse_skip_operation_o(psk),
      .output_in_window_flag_o(pgd), .output_in_window_flag_oe_o(oe), .discharge_on_o(dis),
      .internal_bias_rail_off_o(boff), .hiccup_active_o(hic), .standby_o(stb),
      .cfg_sampling_o(smp), .cfg_valid_o(cv), .cfg_limit_o(clim), .cfg_freq_o(cfrq));
   bfs_host_model u_bfs_host_model (.clk_i(clk_i), .en_req_i(en_req), .pg_oe_i(oe),
      .pg_dat_i(pgd), .en_on_o(en_on), .en_off_o(en_off), .pg_wire_o(pg_wire));
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   task wt(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task summarize;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Start-up with the top current limit asked together with the top frequency
   task t_startup;
      @(posedge clk_i);
      en_req <= 1'b1;
      wt(12);
      chk("pullup", 2'h1, pu);
      wt(T * 7 / 2);
      chk("sampling", 2'h1, smp);
      chk("early ramp", 2'h0, rel);
      wt(4 * T);
      chk("limit", LIM_FALLBACK, clim);
      chk("freq", FREQ_HIGHEST, cfrq);
      chk("prebias sw", 2'h0, sw);
      @(posedge clk_i);
      {rf, ex} <= 2'b11;
      wt(4);
      chk("sw", 2'h1, sw);
      chk("ext ref", 2'h1, rext);
      chk("ramp pg", 2'h1, oe);
      chk("ramp pg wire", 2'h0, pg_wire);
      @(posedge clk_i);
      {ssd, win} <= 2'b11;
      wt(T);
      chk("pg early", 2'h1, oe);
      wt(4 * T);
      chk("pg wire", 2'h1, pg_wire);
      $display("startup done");
   endtask
   // Clamp, overvoltage, valley limit and undervoltage while running
   task t_run_faults;
      @(posedge clk_i);
      {cl, zc} <= 2'b11;
      wt(4);
      chk("force", 2'h1, frc);
      chk("neg limit", 2'h1, neg);
      chk("zero off", 2'h0, zoff);
      chk("clamp pg", 2'h0, oe);
      @(posedge clk_i);
      {cl, ov} <= 2'b01;
      wt(5);
      chk("zero off", 2'h1, zoff);
      chk("ov dis", 2'h1, dis);
      chk("ov pg", 2'h1, oe);
      @(posedge clk_i);
      {ov, oc} <= 2'b01;
      wt(4);
      chk("hold", 2'h1, hold);
      @(posedge clk_i);
      {oc, uv} <= 2'b01;
      wt(2 * T);
      chk("uv wait", 2'h1, sw);
      wt(3 * T);
      chk("hiccup", 2'h1, hic);
      chk("hiccup sw", 2'h0, sw);
      @(posedge clk_i);
      uv <= 1'b0;
      wt(5 * T);
      chk("restart", 2'h1, sw);
      $display("run faults done");
   endtask
   // Lockout over a clamp, then a valley trip in pre-bias, before switching
   task t_lockout_oc;
      @(posedge clk_i);
      {lk, cl, rf} <= 3'b110;
      wt(5);
      chk("lk sw", 2'h0, sw);
      chk("lk clamp", 2'h0, frc);
      chk("lk dis", 2'h1, dis);
      @(posedge clk_i);
      {lk, cl} <= 2'b00;
      wt(4);
      chk("resume", 2'h1, rel);
      @(posedge clk_i);
      oc <= 1'b1;
      wt(4);
      chk("oc hiccup", 2'h1, hic);
      @(posedge clk_i);
      {oc, rf} <= 2'b01;
      wt(6 * T);
      chk("oc restart", 2'h1, sw);
      $display("lockout done");
   endtask
   // Hot die while running; new mode inputs must not be taken
   task t_thermal;
      wt(3 * T);
      chk("pg out", 2'h0, oe);
      @(posedge clk_i);
      {t1, sk, frq} <= 4'b1001;
      wt(4);
      chk("hot sw", 2'h0, sw);
      chk("hot gnd", 2'h1, gnd);
      chk("hot pg", 2'h1, oe);
      @(posedge clk_i);
      t2 <= 1'b1;
      wt(5);
      chk("hot dis", 2'h1, dis);
      chk("bias off", 2'h1, boff);
      @(posedge clk_i);
      {t1, t2} <= 2'b00;
      wt(5);
      chk("cool sw", 2'h1, sw);
      chk("kept limit", LIM_FALLBACK, clim);
      chk("kept freq", FREQ_HIGHEST, cfrq);
      chk("kept skip", 2'h1, psk);
      $display("thermal done");
   endtask
   // Slow enable fall: the pin crosses the band before standby
   task t_standby;
      @(posedge clk_i);
      en_req <= 1'b0;
      wt(4);
      chk("band hold", 2'h1, sw);
      wt(8);
      chk("standby", 2'h1, stb);
      chk("low pullup", 2'h0, pu);
      chk("stby dis", 2'h1, dis);
      $display("standby done");
   endtask
   // Supply cycle with a hot die: nothing sampled until it cools
   task t_hot_start;
      @(posedge clk_i);
      {reset_i, t1, en_req} <= 3'b111;
      wt(2);
      @(posedge clk_i);
      reset_i <= 1'b0;
      wt(8 * T);
      chk("hot cfg", 2'h0, cv);
      @(posedge clk_i);
      t1 <= 1'b0;
      wt(8 * T);
      chk("new limit", LIM_HIGHEST, clim);
      chk("new freq", 2'h1, cfrq);
      chk("ccm sw", 2'h1, sw);
      chk("ccm", 2'h0, psk);
      $display("hot start done");
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      t_startup;
      t_run_faults;
      t_lockout_oc;
      t_thermal;
      t_standby;
      t_hot_start;
      summarize;
   end
   // Cut a hang short well past the expected length of all tests
   initial begin
      repeat (70 * T) @(posedge clk_i);
      bad_count++;
      summarize;
   end
endmodule
bind bfs_sequencer bfs_sequencer_assertions u_bfs_sequencer_assertions (.*);
